// file: design/bidirectional_port_direction_ctrl.v
// Top of the bidirectional port block with its Avalon-MM register slave
`timescale 1ns/100ps
`include "gpio_bidir_regs.vh"
module bidirectional_port_direction_ctrl
(
    // Clock, reset, enable
    input wire clk,
    input wire rstn,
    input wire ce,
    // Avalon-MM slave
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire waitrequest,
    // Pins of port a0
    input wire [3:0] bidir_port_a0_in,
    output wire [3:0] bidir_port_a0_out,
    output wire [3:0] bidir_port_a0_oe,
    // Pins of port b0
    input wire [3:0] bidir_port_b0_in,
    output wire [3:0] bidir_port_b0_out,
    output wire [3:0] bidir_port_b0_oe,
    // Pins of port c0
    input wire [3:0] bidir_group_port_c0_in,
    output wire [3:0] bidir_group_port_c0_out,
    output wire [3:0] bidir_group_port_c0_oe,
    // Pins of port a1
    input wire [3:0] bidir_port_a1_in,
    output wire [3:0] bidir_port_a1_out,
    output wire [3:0] bidir_port_a1_oe
);

////////////////////////////////////////////////////////////////////////
// Bus phase: a read answers one cycle after it is seen, a write at once
reg rd_done_r;
reg [31:0] rdata_r;
reg [31:0] rdata_nxt;
wire [7:0] idx;
wire is_word;
wire wr_go;
wire rd_go;

assign idx = address[9:2];
assign is_word = (address[1:0] == 2'h0);
assign wr_go = ce && write && !read && byteenable[0];
assign rd_go = ce && read && !write && !rd_done_r;
assign waitrequest = read ? !rd_done_r : 1'b0;
assign readdata = rdata_r;

// Read-modify-write through the modify index is not offered: latches
// of a0 bits 3,2 in output mode are refreshed from pins on any a0 write instead
function [2:0] decode;
    input [7:0] ix;
    begin
        case (ix)
            `IDX_PORT_A0: decode = 3'h1;
            `IDX_PORT_B0: decode = 3'h2;
            `IDX_PORT_C0: decode = 3'h3;
            `IDX_PORT_A1: decode = 3'h4;
            default: decode = 3'h0;
        endcase
    end
endfunction

wire [2:0] wr_port;
assign wr_port = (wr_go && is_word) ? decode(idx) : 3'h0;

////////////////////////////////////////////////////////////////////////
// Soft resets: CE reset and clock stop, one-shot control bits
wire ctrl_we;
wire soft_clr;
assign ctrl_we = wr_go && is_word && (idx == `IDX_CTRL);
assign soft_clr = ctrl_we && (writedata[`CTRL_STOP_BIT] || writedata[`CTRL_CE_BIT]);

////////////////////////////////////////////////////////////////////////
// Direction registers
wire [3:0] dir_a0;
wire [3:0] dir_b0;
wire [3:0] dir_a1;
wire [3:0] dir_c0_reg;
wire [3:0] dir_c0;

dir_reg4 u_dir_a0
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .soft_clr(soft_clr),
    .we(wr_go && is_word && idx == `IDX_DIR_A0),
    .wmask(4'hf),
    .wdata(writedata[3:0]),
    .dir_r(dir_a0)
);

dir_reg4 u_dir_b0
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .soft_clr(soft_clr),
    .we(wr_go && is_word && idx == `IDX_DIR_B0),
    .wmask(4'hf),
    .wdata(writedata[3:0]),
    .dir_r(dir_b0)
);

dir_reg4 u_dir_a1
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .soft_clr(soft_clr),
    .we(wr_go && is_word && idx == `IDX_DIR_A1),
    .wmask(4'hf),
    .wdata(writedata[3:0]),
    .dir_r(dir_a1)
);

// Only bit 0 is stored; upper bits read zero
dir_reg4 u_dir_c0
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .soft_clr(soft_clr),
    .we(wr_go && is_word && idx == `IDX_DIR_C0),
    .wmask(4'h1),
    .wdata(writedata[3:0]),
    .dir_r(dir_c0_reg)
);

assign dir_c0 = {4{dir_c0_reg[`GROUP_DIR_BIT]}};

////////////////////////////////////////////////////////////////////////
// Port cells
wire [3:0] rd_a0;
wire [3:0] rd_b0;
wire [3:0] rd_c0;
wire [3:0] rd_a1;
wire [3:0] a0_wdata;
wire [3:0] a0_pin_mask;

// A0 bits 3,2 in output mode take the pin level, not the written data
assign a0_pin_mask = `A0_PIN_READ_MASK & dir_a0;
assign a0_wdata = (writedata[3:0] & ~a0_pin_mask) | (bidir_port_a0_in & a0_pin_mask);

port_pin_cell u_a0
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .latch_we(wr_port == 3'h1),
    .latch_wdata(a0_wdata),
    .dir_out(dir_a0),
    .pin_read_mask(`A0_PIN_READ_MASK),
    .pin_in(bidir_port_a0_in),
    .pin_out(bidir_port_a0_out),
    .pin_oe(bidir_port_a0_oe),
    .rd_value(rd_a0)
);

port_pin_cell u_b0
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .latch_we(wr_port == 3'h2),
    .latch_wdata(writedata[3:0]),
    .dir_out(dir_b0),
    .pin_read_mask(4'h0),
    .pin_in(bidir_port_b0_in),
    .pin_out(bidir_port_b0_out),
    .pin_oe(bidir_port_b0_oe),
    .rd_value(rd_b0)
);

port_pin_cell u_c0
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .latch_we(wr_port == 3'h3),
    .latch_wdata(writedata[3:0]),
    .dir_out(dir_c0),
    .pin_read_mask(4'h0),
    .pin_in(bidir_group_port_c0_in),
    .pin_out(bidir_group_port_c0_out),
    .pin_oe(bidir_group_port_c0_oe),
    .rd_value(rd_c0)
);

port_pin_cell u_a1
(
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .latch_we(wr_port == 3'h4),
    .latch_wdata(writedata[3:0]),
    .dir_out(dir_a1),
    .pin_read_mask(4'h0),
    .pin_in(bidir_port_a1_in),
    .pin_out(bidir_port_a1_out),
    .pin_oe(bidir_port_a1_oe),
    .rd_value(rd_a1)
);

////////////////////////////////////////////////////////////////////////
// Read mux; unmapped or misaligned reads return zero
always @*
begin
    rdata_nxt = 32'h0;
    if (is_word)
    begin
        case (idx)
            `IDX_PORT_A0: rdata_nxt[3:0] = rd_a0;
            `IDX_PORT_B0: rdata_nxt[3:0] = rd_b0;
            `IDX_PORT_C0: rdata_nxt[3:0] = rd_c0;
            `IDX_PORT_A1: rdata_nxt[3:0] = rd_a1;
            `IDX_DIR_A0: rdata_nxt[3:0] = dir_a0;
            `IDX_DIR_B0: rdata_nxt[3:0] = dir_b0;
            `IDX_DIR_A1: rdata_nxt[3:0] = dir_a1;
            `IDX_DIR_C0: rdata_nxt[3:0] = dir_c0_reg;
            default: rdata_nxt = 32'h0;
        endcase
    end
end

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        rd_done_r <= 1'b0;
        rdata_r <= 32'h0;
    end
    else if (ce)
    begin
        rd_done_r <= rd_go;
        if (rd_go)
            rdata_r <= rdata_nxt;
    end
end

endmodule // bidirectional_port_direction_ctrl

// file: design/gpio_bidir_regs.vh
// Register map, field positions and reset values for the bidirectional port block
// Function
// - Direction register bit selects pin mode
// - Port c0 direction set as one group
// - Input-mode pin output driver disabled
// - Input-mode read returns pin level
// - Input-mode write still updates latch
// - Output-mode pin drives its latch
// - Write one drives high, zero low
// - Output-mode read returns latch contents
// - Port a0 bits 3,2 read pin level
// - Port a1 direction bit one means output
// - Port a1 direction at 35h, clears 0
// - Port c0 direction at 27h, bit0 only
// - Ports a0, b0, a1 per-pin direction
// - Reset/stop forces input, latches retained
// - Modify-write on a0 loads pin levels
`ifndef GPIO_BIDIR_REGS_VH
`define GPIO_BIDIR_REGS_VH

`define PORT_W 4
`define ADDR_W 8
`define DATA_W 32

// Word indices; byte address is four times the index
`define IDX_PORT_A0 8'h70
`define IDX_PORT_B0 8'h71
`define IDX_PORT_C0 8'h72
`define IDX_PORT_A1 8'h73
`define IDX_DIR_C0 8'h27
`define IDX_DIR_B0 8'h36
`define IDX_DIR_A0 8'h37
`define IDX_DIR_A1 8'h35
`define IDX_CTRL 8'h74

`define DIR_RESET 4'h0
`define GROUP_DIR_BIT 0
`define CTRL_STOP_BIT 0
`define CTRL_CE_BIT 1
`define A0_PIN_READ_MASK 4'hc

// Port select codes
`define SEL_A0 2'h0
`define SEL_B0 2'h1
`define SEL_C0 2'h2
`define SEL_A1 2'h3

`endif

// file: design/port_pin_cell.v
// One 4-bit bidirectional port: latch, pin drive and read select
`timescale 1ns/100ps
`include "gpio_bidir_regs.vh"
module port_pin_cell
(
    // Clock and reset
    input wire clk,
    input wire rstn,
    input wire ce,
    // Latch write
    input wire latch_we,
    input wire [3:0] latch_wdata,
    // Direction and read policy
    input wire [3:0] dir_out,
    input wire [3:0] pin_read_mask,
    // Pins
    input wire [3:0] pin_in,
    output wire [3:0] pin_out,
    output wire [3:0] pin_oe,
    // Read value
    output wire [3:0] rd_value
);

reg [3:0] latch_r;

////////////////////////////////////////////////////////////////////////
// Latch is kept apart from direction, survives soft resets
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        latch_r <= 4'h0;
    else if (ce && latch_we)
        latch_r <= latch_wdata;
end

assign pin_out = latch_r;
assign pin_oe = dir_out;

genvar i;
generate
    for (i = 0; i < `PORT_W; i = i + 1)
    begin : g_rd
        assign rd_value[i] = (dir_out[i] && !pin_read_mask[i]) ? latch_r[i] : pin_in[i];
    end
endgenerate

endmodule // port_pin_cell

// file: design/dir_reg4.v
// Four-bit direction register with hard and soft clear
`timescale 1ns/100ps
`include "gpio_bidir_regs.vh"
module dir_reg4
(
    // Clock and reset
    input wire clk,
    input wire rstn,
    input wire ce,
    // Soft clear (CE reset or clock stop)
    input wire soft_clr,
    // Write
    input wire we,
    input wire [3:0] wmask,
    input wire [3:0] wdata,
    // State
    output reg [3:0] dir_r
);

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        dir_r <= `DIR_RESET;
    else if (ce)
    begin
        if (soft_clr)
            dir_r <= `DIR_RESET;
        else if (we)
            dir_r <= wdata & wmask;
    end
end

endmodule // dir_reg4

// file: tb/gpio_bidir_properties.sv
// Port block checks
`timescale 1ns/100ps
module gpio_bidir_properties
(
    // Clock and reset
    input wire clk,
    input wire rstn,
    input wire ce,
    // Bus
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    // Pins
    input wire [3:0] bidir_port_b0_oe,
    input wire [3:0] bidir_group_port_c0_oe,
    input wire [3:0] bidir_port_a1_out,
    input wire [3:0] bidir_port_a1_oe
);
    wire [3:0] wd = writedata[3:0];
    wire g = writedata[0];
    wire wr = write && ce && byteenable[0];
    wire clr = wr && address == 10'h1d0 && wd[1:0] != 2'h0;
    wire [3:0] all_oe = bidir_port_a1_oe | bidir_port_b0_oe | bidir_group_port_c0_oe;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    AST_C0_GROUP: assert property (
        bidir_group_port_c0_oe == 4'h0 || bidir_group_port_c0_oe == 4'hf) else $error("c0 split");
    AST_C0_DIR: assert property (
        wr && address == 10'h09c |=> bidir_group_port_c0_oe == {4{$past(g)}}) else $error("c0 dir");
    AST_C0_READ: assert property (
        read && !waitrequest && address == 10'h09c |-> readdata[31:1] == 31'h0)
        else $error("c0 read");
    AST_A1_DIR: assert property (
        wr && address == 10'h0d4 |=> bidir_port_a1_oe == $past(wd)) else $error("a1 dir");
    AST_A1_LATCH: assert property (
        wr && address == 10'h1cc |=> bidir_port_a1_out == $past(wd)) else $error("a1 latch");
    AST_SOFT_CLR: assert property (
        clr |=> all_oe == 4'h0) else $error("soft clear");
    AST_KEEP_LATCH: assert property (
        clr |=> $stable(bidir_port_a1_out)) else $error("latch lost");
    AST_B0_HOLD: assert property (
        !(wr && (address == 10'h0d8 || address == 10'h1d0)) |=> $stable(bidir_port_b0_oe))
        else $error("b0 dir moved");
endmodule // gpio_bidir_properties

bind bidirectional_port_direction_ctrl gpio_bidir_properties chk
(
    .clk, .rstn, .ce, .address, .read, .write, .byteenable, .writedata, .readdata,
    .waitrequest, .bidir_port_b0_oe, .bidir_group_port_c0_oe, .bidir_port_a1_out,
    .bidir_port_a1_oe
);

// file: tb/pin_env.sv
// Outside world of one 4-bit port
`timescale 1ns/100ps
module pin_env
(
    // Block side
    input wire [3:0] out,
    input wire [3:0] oe,
    // Outside level
    input wire [3:0] ext,
    // Outside source holding a pin low, even over a driven high
    input wire [3:0] hold_lo,
    output wire [3:0] lvl
);
    assign lvl = ((oe & out) | (~oe & ext)) & ~hold_lo;
endmodule // pin_env

// file: tb/bidirectional_port_direction_ctrl_tb.sv
// Bench for the port block
`timescale 1ns/100ps
module bidirectional_port_direction_ctrl_tb;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [9:0] adr = 10'h0;
    reg rd_s = 1'b0;
    reg wr_s = 1'b0;
    reg [31:0] wdat = 32'h0;
    reg [3:0] xa0 = 4'h0, xb0 = 4'h0, xa1 = 4'h0, ha0 = 4'h0;
    reg ce_s = 1'b1;
    wire [31:0] rdat;
    wire wreq;
    wire [3:0] a0o, a0e, a0i, b0o, b0e, b0i, c0o, c0e, c0i, a1o, a1e, a1i;
    integer n_mismatch = 0;
    integer comparisons = 0;
    integer i;
    reg [3:0] got;
    initial forever #25 clk = ~clk;
    bidirectional_port_direction_ctrl dut
    (
        .clk(clk), .rstn(rstn), .ce(ce_s), .address(adr), .read(rd_s), .write(wr_s),
        .byteenable(4'hf), .writedata(wdat), .readdata(rdat), .waitrequest(wreq),
        .bidir_port_a0_in(a0i), .bidir_port_a0_out(a0o), .bidir_port_a0_oe(a0e),
        .bidir_port_b0_in(b0i), .bidir_port_b0_out(b0o), .bidir_port_b0_oe(b0e),
        .bidir_group_port_c0_in(c0i), .bidir_group_port_c0_out(c0o),
        .bidir_group_port_c0_oe(c0e), .bidir_port_a1_in(a1i), .bidir_port_a1_out(a1o),
        .bidir_port_a1_oe(a1e)
    );
    pin_env pa0 (.out(a0o), .oe(a0e), .ext(xa0), .hold_lo(ha0), .lvl(a0i));
    pin_env pb0 (.out(b0o), .oe(b0e), .ext(xb0), .hold_lo(4'h0), .lvl(b0i));
    // Port c0 left pulled low outside
    pin_env pc0 (.out(c0o), .oe(c0e), .ext(4'h0), .hold_lo(4'h0), .lvl(c0i));
    pin_env pa1 (.out(a1o), .oe(a1e), .ext(xa1), .hold_lo(4'h0), .lvl(a1i));
    ////////////////////////////////////////////////////////////////////////////////
    task cmp(input [3:0] gv, input [3:0] ev);
        begin
            comparisons = comparisons + 1;
            if (gv !== ev)
            begin
                n_mismatch = n_mismatch + 1;
                $display("Error at %0t: got %h expected %h", $time, gv, ev);
            end
        end
    endtask
    // Ends at the falling edge so pins have settled
    task wr(input [9:0] a, input [3:0] d);
        begin
            @(posedge clk);
            adr <= a;
            wdat <= {28'h0, d};
            wr_s <= 1'b1;
            @(posedge clk);
            while (wreq !== 1'b0)
                @(posedge clk);
            wr_s <= 1'b0;
            @(negedge clk);
        end
    endtask
    task rd(input [9:0] a, input [3:0] e);
        begin
            @(posedge clk);
            adr <= a;
            rd_s <= 1'b1;
            @(posedge clk);
            while (wreq !== 1'b0)
                @(posedge clk);
            got = rdat[3:0];
            rd_s <= 1'b0;
            cmp(got, e);
        end
    endtask
    task end_of_test;
        begin
            $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial
    begin
        #100000;
        n_mismatch = n_mismatch + 1;
        end_of_test;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(10'h0d4, 4'h0);
        rd(10'h09c, 4'h0);
        cmp(a0e | b0e | c0e | a1e, 4'h0);
        $display("Reset test done");
        xa1 <= 4'h5;
        wr(10'h1cc, 4'ha);
        cmp(a1e, 4'h0);
        rd(10'h1cc, 4'h5);
        wr(10'h0d4, 4'h6);
        cmp(a1e, 4'h6);
        cmp(a1o, 4'ha);
        rd(10'h1cc, 4'h3);
        rd(10'h0d4, 4'h6);
        $display("Port a1 test done");
        wr(10'h09c, 4'hf);
        cmp(c0e, 4'hf);
        rd(10'h09c, 4'h1);
        wr(10'h1c8, 4'h9);
        cmp(c0o, 4'h9);
        rd(10'h1c8, 4'h9);
        wr(10'h09c, 4'h0);
        cmp(c0e, 4'h0);
        $display("Port c0 test done");
        @(posedge clk);
        xb0 <= 4'ha;
        wr(10'h0d8, 4'h5);
        cmp(b0e, 4'h5);
        rd(10'h1c4, 4'ha);
        wr(10'h1c4, 4'h6);
        cmp(b0o, 4'h6);
        rd(10'h1c4, 4'he);
        xa0 <= 4'h4;
        wr(10'h1c0, 4'hc);
        wr(10'h0dc, 4'hf);
        cmp(a0o, 4'hc);
        rd(10'h1c0, 4'hc);
        wr(10'h1c0, 4'h3);
        cmp(a0o, 4'hf);
        // Bit 2 pulled low outside while driven high
        @(posedge clk);
        ha0 <= 4'h4;
        rd(10'h1c0, 4'hb);
        wr(10'h1c0, 4'hf);
        cmp(a0o, 4'hb);
        $display("Ports a0 b0 test done");
        // Both soft clear sources: stop and CE reset
        for (i = 1; i < 3; i = i + 1)
        begin
            wr(10'h0d4, 4'hf);
            wr(10'h1d0, i[3:0]);
            cmp(a0e | b0e | a1e, 4'h0);
            cmp(a1o, 4'ha);
        end
        // Power-on reset in mid-run clears direction and latch
        wr(10'h0d4, 4'h9);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        cmp(a1e, 4'h0);
        cmp(a1o, 4'h0);
        rd(10'h09c, 4'h0);
        // Clock enable low: a direction write must not land
        ce_s <= 1'b0;
        wr(10'h0d4, 4'h5);
        cmp(a1e, 4'h0);
        @(posedge clk);
        ce_s <= 1'b1;
        wr(10'h3fc, 4'hf);
        rd(10'h3fc, 4'h0);
        cmp(a1e, 4'h0);
        $display("Clear test done");
        end_of_test;
    end
endmodule // bidirectional_port_direction_ctrl_tb
